/* verilog/ext_irq_pin_ctrl.sv */
// external interrupt pin control, detection, flag and request logic
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module ext_irq_pin_ctrl
  import irq_pin_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              irq_pin,
  output logic                   pull_up_en,
  output logic                   pull_down_en,
  output logic                   irq_req
);
  logic              pull_device_disable_ff;
  logic              polarity_select_ff;
  logic              pin_function_enable_ff;
  logic              event_flag_ff;
  logic              request_enable_ff;
  logic              level_detect_mode_ff;
  logic              pin_prev_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic              pull_up_ff;
  logic              pull_down_ff;
  logic              irq_req_ff;
  logic              pin_clean;

  pin_sync u_pin_sync
  (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .pin_async (irq_pin),
    .pin_clean (pin_clean)
  );

  // register decode
  wire sel        = (reg_addr == STAT_CTRL_OFFS); // RULE_11
  wire wr_sel     = reg_wr && sel;
  wire rd_sel     = reg_rd && sel;
  wire ack_write  = wr_sel && reg_wdata[BIT_ACK]; // RULE_06

  // pin seen in asserted sense: high means active for either polarity
  wire pin_active = polarity_select_ff ? pin_clean : ~pin_clean; // RULE_02
  wire prev_active = polarity_select_ff ? pin_prev_ff : ~pin_prev_ff;
  wire edge_hit   = pin_active && !prev_active;
  wire level_hit  = level_detect_mode_ff && pin_active; // RULE_10
  wire event_hit  = pin_function_enable_ff && (edge_hit || level_hit); // RULE_13

  // set beats clear; level mode holds flag while pin asserted
  wire flag_hold  = level_detect_mode_ff && pin_active && pin_function_enable_ff; // RULE_08
  wire nxt_flag   = event_hit ? 1'b1 :
                    (ack_write && !flag_hold) ? 1'b0 : event_flag_ff; // RULE_05

  wire pull_on    = pin_function_enable_ff && !pull_device_disable_ff; // RULE_01
  wire nxt_pull_up   = pull_on && !polarity_select_ff;
  wire nxt_pull_down = pull_on && polarity_select_ff; // RULE_03

  // bit 7 and ack read as zero
  wire [DATA_W-1:0] stat_word = {1'b0, // RULE_12
                                 pull_device_disable_ff,
                                 polarity_select_ff,
                                 pin_function_enable_ff,
                                 event_flag_ff,
                                 1'b0, // RULE_07
                                 request_enable_ff,
                                 level_detect_mode_ff};
  wire [DATA_W-1:0] nxt_rdata = rd_sel ? stat_word : UNMAPPED_READ;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pull_device_disable_ff <= STAT_CTRL_RST[BIT_PULL_DIS];
      polarity_select_ff     <= STAT_CTRL_RST[BIT_POLARITY];
      pin_function_enable_ff <= STAT_CTRL_RST[BIT_PIN_EN];
      request_enable_ff      <= STAT_CTRL_RST[BIT_REQ_EN];
      level_detect_mode_ff   <= STAT_CTRL_RST[BIT_LEVEL_MODE];
    end
    else if (wr_sel)
    begin
      pull_device_disable_ff <= reg_wdata[BIT_PULL_DIS];
      polarity_select_ff     <= reg_wdata[BIT_POLARITY];
      pin_function_enable_ff <= reg_wdata[BIT_PIN_EN]; // RULE_04
      request_enable_ff      <= reg_wdata[BIT_REQ_EN];
      level_detect_mode_ff   <= reg_wdata[BIT_LEVEL_MODE];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      event_flag_ff <= STAT_CTRL_RST[BIT_FLAG];
      pin_prev_ff   <= 1'b0;
      rdata_ff      <= '0;
      pull_up_ff    <= 1'b0;
      pull_down_ff  <= 1'b0;
      irq_req_ff    <= 1'b0;
    end
    else
    begin
      event_flag_ff <= nxt_flag;
      pin_prev_ff   <= pin_clean;
      rdata_ff      <= nxt_rdata;
      pull_up_ff    <= nxt_pull_up;
      pull_down_ff  <= nxt_pull_down;
      irq_req_ff    <= request_enable_ff && nxt_flag; // RULE_09
    end
  end

  assign reg_rdata    = rdata_ff;
  assign pull_up_en   = pull_up_ff;
  assign pull_down_en = pull_down_ff;
  assign irq_req      = irq_req_ff;
endmodule

/* verilog/irq_pin_pkg.sv */
// constants for the external interrupt pin status/control block
// Contract
// RULE_01 - bit 6 set turns the internal pull device off while pin enabled
// RULE_02 - bit 5 selects polarity: 0 falling/low, 1 rising/high
// RULE_03 - rising polarity with pull enabled makes the pull a pull-down
// RULE_04 - bit 4 enables the interrupt pin function
// RULE_05 - bit 3 is a read-only flag set on a qualifying pin event
// RULE_06 - writing 1 to bit 2 clears the flag; writing 0 does nothing
// RULE_07 - acknowledge bit always reads back as zero
// RULE_08 - in level mode acknowledge cannot clear flag while pin stays asserted
// RULE_09 - bit 1 set raises the interrupt output whenever the flag is set
// RULE_10 - bit 0 selects edge-only or edge-and-level detection
// RULE_11 - the status/control register is a single 8-bit register
// RULE_12 - bit 7 is unimplemented, reads zero, writes ignored
// RULE_13 - with pin function disabled: no detection, no flag set, pull off
package irq_pin_pkg;
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned ADDR_W         = 4;
  localparam logic [3:0]  STAT_CTRL_OFFS = 4'h0;
  localparam int unsigned BIT_PULL_DIS   = 6;
  localparam int unsigned BIT_POLARITY   = 5;
  localparam int unsigned BIT_PIN_EN     = 4;
  localparam int unsigned BIT_FLAG       = 3;
  localparam int unsigned BIT_ACK        = 2;
  localparam int unsigned BIT_REQ_EN     = 1;
  localparam int unsigned BIT_LEVEL_MODE = 0;
  localparam logic [7:0]  STAT_CTRL_RST  = 8'h00;
  localparam logic [7:0]  UNMAPPED_READ  = 8'h00;
  localparam int unsigned SYNC_STAGES    = 3;
endpackage

/* verilog/pin_sync.sv */
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module pin_sync
  import irq_pin_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic pin_async,
  output logic      pin_clean
);
  logic [SYNC_STAGES-1:0] stage_ff;
  logic                   clean_ff;
  wire                    agree = (stage_ff[1] == stage_ff[2]);

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage_ff <= '0;
      clean_ff <= 1'b0;
    end
    else
    begin
      stage_ff <= {stage_ff[1:0], pin_async};
      if (agree)
        clean_ff <= stage_ff[2];
    end
  end

  assign pin_clean = clean_ff;
endmodule

/* verif/ext_irq_pin_ctrl_monitor.sv */
// assertion checker for the interrupt pin block
`timescale 1ns/1ps
module ext_irq_pin_ctrl_monitor (
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       pull_up_en,
  input wire logic       pull_down_en,
  input wire logic       irq_req
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  wire cw = reg_wr && reg_addr == 4'h0;
  a_pull_excl: assert property (!(pull_up_en && pull_down_en)) else $error("pulls both on");
  a_pull_dis: assert property (cw && reg_wdata[6] |->
    ##2 !pull_up_en && !pull_down_en) else $error("pull on");
  a_pin_off: assert property (cw && !reg_wdata[4] |->
    ##2 !pull_up_en && !pull_down_en) else $error("pull on");
  a_pull_dir: assert property (cw && reg_wdata[4] && !reg_wdata[6] |->
    ##2 pull_down_en == $past(reg_wdata[5], 2) && (pull_up_en ^ pull_down_en)) else $error("pull side");
  a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray data");
  a_rd_unmap: assert property (reg_rd && reg_addr != 4'h0 |=> reg_rdata == 8'h00) else $error("unmapped");
  a_rd_zero: assert property ($past(reg_rd) |-> !reg_rdata[7] && !reg_rdata[2]) else $error("bit set");
  a_req_gate: assert property (cw && !reg_wdata[1] ##1 !reg_wr |=> !irq_req) else $error("req on");
endmodule
bind ext_irq_pin_ctrl ext_irq_pin_ctrl_monitor mon (.*);

/* verif/irq_source.sv */
// far-side source driving the interrupt pin, sometimes late
`timescale 1ns/1ps
module irq_source (
  input  wire logic sys_clk,
  input  wire logic lvl,
  output logic      irq_pin
);
  initial irq_pin = 1'b0;
  always
  begin
    @(posedge sys_clk);
    repeat ($urandom_range(2, 0)) @(posedge sys_clk);
    irq_pin <= lvl;
  end
endmodule

/* verif/ext_irq_pin_ctrl_tb.sv */
// random and corner tests of the interrupt pin block
`timescale 1ns/1ps
module ext_irq_pin_ctrl_tb;
  logic       sys_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, lvl = 0;
  logic [3:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata, q, v;
  logic       irq_pin, pull_up_en, pull_down_en, irq_req;
  int         mismatches = 0, n_tests = 0;
  ext_irq_pin_ctrl dut (.*);
  irq_source src (.*);
  initial forever #12.5 sys_clk = ~sys_clk;
  task automatic chk(string n, logic [7:0] s, e);
    n_tests++;
    if (s !== e)
    begin
      mismatches++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask
  // read-back of a written word: bit 7 and ack zero, flag as given
  function automatic logic [7:0] exp_word(logic [7:0] w, logic f);
    return {1'b0, w[6:4], f, 1'b0, w[1:0]};
  endfunction
  task automatic wr(logic [7:0] d);
    @(posedge sys_clk) {reg_wr, reg_addr, reg_wdata} <= {5'h10, d};
    @(posedge sys_clk) reg_wr <= 0;
  endtask
  task automatic rd(logic [3:0] a);
    @(posedge sys_clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge sys_clk) reg_rd <= 0;
    #1 q = reg_rdata;
  endtask
  task automatic final_report;
    if (mismatches == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    void'($urandom(32'h9ed4));
    repeat (2) @(posedge sys_clk);
    rst_b <= 1;
    for (int c = 0; c < 4; c++)
    begin
      v = {2'b0, c[1], 1'b1, 2'b0, 1'b1, c[0]};
      wr(8'h04);
      wr(8'h04);
      lvl <= !c[1];
      repeat (10) @(posedge sys_clk);
      wr(v | 8'h04);
      rd(0);
      chk("ctrl", q, v);
      chk("pulls", {6'h0, pull_up_en, pull_down_en}, {6'h0, !c[1], c[1]});
      lvl <= c[1];
      for (int i = 0; i < 16 && irq_req !== 1; i++)
      begin
        @(posedge sys_clk);
        #1;
      end
      chk("req", {7'h0, irq_req}, 8'h01);
      if (irq_req !== 1) final_report();
      wr(v);
      rd(0);
      chk("noack", q, v | 8'h08);
      wr(v | 8'h04);
      rd(0);
      chk("hold", q, exp_word(v, c[0]));
      lvl <= !c[1];
      repeat (10) @(posedge sys_clk);
      wr(v | 8'h04);
      rd(0);
      chk("clear", q, v);
      chk("req_off", {7'h0, irq_req}, 8'h00);
    end
    for (int k = 0; k < 8; k++)
    begin
      v = 8'($urandom);
      wr(v & 8'hef | 8'h04);
      lvl <= 1'($urandom);
      repeat (10) @(posedge sys_clk);
      rd(0);
      chk("dis", q, exp_word(v & 8'hef, 1'b0));
      chk("off", {6'h0, pull_up_en, pull_down_en}, 8'h00);
      rd(4'($urandom_range(15, 1)));
      chk("unmap", q, 8'h00);
    end
    wr(8'h72);
    rd(0);
    chk("pdis", {6'h0, pull_up_en, pull_down_en}, 8'h00);
    wr(8'h12);
    rd(0);
    chk("pup", {6'h0, pull_up_en, pull_down_en}, 8'h02);
    // second reset in mid-run, config and outputs back to idle
    @(posedge sys_clk) rst_b <= 0;
    @(posedge sys_clk) rst_b <= 1;
    rd(0);
    chk("rst", q, 8'h00);
    chk("rst_pull", {6'h0, pull_up_en, pull_down_en}, 8'h00);
    chk("rst_req", {7'h0, irq_req}, 8'h00);
    final_report();
  end
endmodule
